// *** include/frx_pkg.sv ***
// What this block does
// - Serial input comes from twisted-pair or optical receiver, chosen by mode.
// - Serial bits are converted NRZI to NRZ before anything else, unaligned.
// - Descrambler locks after an idle run of 40 or more bits, loading LFSR.
// - Once locked, each bit is XORed with the local LFSR output.
// - Lock starts a 722 microsecond hold countdown.
// - Thirty consecutive descrambled ones reload the hold countdown.
// - Hold expiry drops lock, resets descrambler and restarts acquisition.
// - Search unaligned stream for 11000 10001, then fix symbol boundary.
// - Start delimiter after idle becomes two preamble nibbles 0101.
// - Data code-groups translate by fixed table into four-bit nibbles.
// - Translation stops when end delimiter starting with 01101 is seen.
// - Nibbles drive four receive data lines, bit zero least significant.
// - Code-group 11111 is idle fill with no nibble value.
// - 00100 is transmit error; other unassigned groups are invalid.
// - Data valid rises with first delimiter nibble, falls on end or loss.
// - While valid, receive error marks every invalid code-group.
// - Carrier without start delimiter gives error and 1110 until two idles.
// - Fibre mode bypasses the descrambler.
package frx_pkg;

   // Receive clock rate and hold interval.
   localparam int CLK_MHZ = 250;
   localparam int HOLD_US = 722;
   localparam int HOLD_CYCLES = HOLD_US * CLK_MHZ;
   localparam int HOLD_W = 20;

   // Run lengths of ones.
   localparam logic [5:0] IDLE_LOCK_BITS = 6'h28; // 40 bits
   localparam logic [5:0] IDLE_HOLD_BITS = 6'h1E; // 30 bits

   // Scrambler polynomial length.
   localparam int LFSR_W = 11;

   // Code-groups.
   localparam logic [4:0] CG_IDLE = 5'h1F;
   localparam logic [4:0] CG_J = 5'h18;
   localparam logic [4:0] CG_K = 5'h11;
   localparam logic [4:0] CG_T = 5'h0D;
   localparam logic [4:0] CG_R = 5'h07;
   localparam logic [4:0] CG_H = 5'h04;
   localparam logic [9:0] CG_JK = 10'h311;

   // Nibble values.
   localparam logic [3:0] NIB_PRE = 4'h5;
   localparam logic [3:0] NIB_BADSSD = 4'hE;

   // Buffer word: error flag and nibble.
   localparam int BUF_W = 5;

   typedef enum logic [1:0] {
      FRX_IDLE,
      FRX_DATA,
      FRX_BADSSD
   } frx_state_t;

endpackage : frx_pkg

// *** src/frx_buf2.sv ***
`timescale 1ns/1ps
module frx_buf2
   import frx_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Fill side.
   input wire logic in_valid,
   input wire logic [BUF_W-1:0] in_data,
   output logic in_ready,
   // Drain side.
   output logic out_valid,
   output logic [BUF_W-1:0] out_data,
   input wire logic out_ready
);

   logic [BUF_W-1:0] mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];

   // Pointers and fill level.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         count <= 2'(count + {1'b0, push} - {1'b0, pop});
      end
   end

   // Storage needs no reset; empty entries are never presented.
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr] <= in_data;
   end

endmodule : frx_buf2

// *** src/frx_dec5b.sv ***
`timescale 1ns/1ps
module frx_dec5b
   import frx_pkg::*;
(
   // Code-group in.
   input wire logic [4:0] code,
   // Nibble and validity out.
   output logic [3:0] nibble,
   output logic is_data
);

   // Fixed table; undefined groups give zero with is_data low.
   always_comb begin
      is_data = 1'b1;
      unique case (code)
         5'h1E: nibble = 4'h0;
         5'h09: nibble = 4'h1;
         5'h14: nibble = 4'h2;
         5'h15: nibble = 4'h3;
         5'h0A: nibble = 4'h4;
         5'h0B: nibble = 4'h5;
         5'h0E: nibble = 4'h6;
         5'h0F: nibble = 4'h7;
         5'h12: nibble = 4'h8;
         5'h13: nibble = 4'h9;
         5'h16: nibble = 4'hA;
         5'h17: nibble = 4'hB;
         5'h1A: nibble = 4'hC;
         5'h1B: nibble = 4'hD;
         5'h1C: nibble = 4'hE;
         5'h1D: nibble = 4'hF;
         default: begin
            // Idle, delimiters, H and V have no nibble value.
            nibble = 4'h0;
            is_data = 1'b0;
         end
      endcase
   end

endmodule : frx_dec5b

// *** src/frx_rx_pcs.sv ***
`timescale 1ns/1ps
module frx_rx_pcs
   import frx_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Line side: one recovered bit per clock with its strobe.
   input wire logic fibre_mode,
   input wire logic tp_bit,
   input wire logic tp_bit_valid,
   input wire logic fx_bit,
   input wire logic fx_bit_valid,
   input wire logic signal_ok,
   input wire logic carrier,
   // Nibble stream toward the MAC.
   output logic [3:0] rx_data,
   output logic rx_dv,
   output logic rx_er,
   output logic rx_valid,
   input wire logic rx_ready,
   // Status.
   output logic scr_locked
);

   logic line_bit;
   logic line_strobe;
   logic prev_line;
   logic nrz;
   logic nrz_v;
   logic [LFSR_W-1:0] lfsr;
   logic [5:0] ones_run;
   logic locked;
   logic [HOLD_W-1:0] hold;
   logic desc_bit;
   logic desc_v;
   logic [5:0] dones;
   logic [9:0] shreg;
   logic aligned;
   logic [2:0] bitcnt;
   logic sym_v;
   logic [4:0] sym;
   logic [4:0] prev_sym;
   logic [3:0] dec_nib;
   logic dec_ok;
   frx_state_t state;
   logic idle_seen;
   logic emit;
   logic [BUF_W-1:0] emit_word;
   logic buf_ready;
   logic buf_valid;
   logic [BUF_W-1:0] buf_word;
   logic dv_flag;
   logic [1:0] idle_cnt;
   logic stall;
   logic next_lfsr_bit;
   logic hold_reload;
   logic lock_drop;
   logic [9:0] hist;
   logic ssd_idle;
   logic ssd_exit;

   // Source choice by mode; a full buffer halts new bits at the source.
   // A bit offered while the buffer is full is lost, so the line side
   // must never outrun the MAC by more than the two buffered nibbles.
   assign line_bit = fibre_mode ? fx_bit : tp_bit;
   assign stall = !buf_ready;
   assign line_strobe = (fibre_mode ? fx_bit_valid : tp_bit_valid) && !stall;

   // NRZI decoding: a transition is a one.
   // No symbol boundary is known yet at this point; the decoded bits are
   // handed on one at a time and alignment happens much further down.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prev_line <= 1'b0;
         nrz <= 1'b0;
         nrz_v <= 1'b0;
      end else begin
         nrz_v <= line_strobe;
         if (line_strobe) begin
            prev_line <= line_bit;
            nrz <= line_bit ^ prev_line;
         end
      end
   end

   // Scrambled idle is all ones, so a raw ones run of 40 means the
   // received bits equal the keystream complement; loading inverted
   // bits then tracks the remote LFSR (x^11 + x^9 + 1).
   assign next_lfsr_bit = lfsr[10] ^ lfsr[8];

   // Run of raw scrambled-idle agreement before lock.
   // The first eleven bits only fill the keystream register, so a short
   // run of agreement there means nothing; only a long run is trusted.
   always_ff @(posedge clk) begin
      if (!nrst || lock_drop) begin
         ones_run <= 6'h0;
      end else if (nrz_v) begin
         if (locked || (nrz != ~next_lfsr_bit)) ones_run <= 6'h0;
         else if (ones_run != IDLE_LOCK_BITS) ones_run <= ones_run + 6'h1;
      end
   end

   // Keystream register: loaded from the line until locked.
   // After lock it free-runs; a hold-timer expiry clears it so that the next
   // acquisition does not start from a drifted state.
   always_ff @(posedge clk) begin
      if (!nrst || lock_drop) begin
         lfsr <= '0;
      end else if (nrz_v) begin
         if (locked) lfsr <= {lfsr[9:0], next_lfsr_bit};
         else lfsr <= {lfsr[9:0], ~nrz};
      end
   end

   // Lock and hold timer.
   // A reload in the very cycle of expiry wins, so a link that just
   // delivered its idle run is never dropped by a race with the count.
   always_ff @(posedge clk) begin
      if (!nrst || fibre_mode) begin
         locked <= 1'b0;
         hold <= '0;
      end else if (!locked) begin
         if (nrz_v && ones_run == IDLE_LOCK_BITS - 6'h1
             && nrz == ~next_lfsr_bit) begin
            locked <= 1'b1;
            hold <= HOLD_W'(HOLD_CYCLES - 1);
         end
      end else if (hold_reload) begin
         hold <= HOLD_W'(HOLD_CYCLES - 1);
      end else if (hold == '0) begin
         locked <= 1'b0;
      end else begin
         hold <= hold - HOLD_W'(1);
      end
   end

   // Thirty descrambled ones in a row are six idle symbols.
   assign hold_reload = desc_v && desc_bit
                        && dones == IDLE_HOLD_BITS - 6'h1;

   // One-cycle pulse when the hold timer runs out. It clears the keystream
   // register and the agreement run, so acquisition starts from scratch
   // instead of trusting a state that has already drifted from the line.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lock_drop <= 1'b0;
      end else begin
         lock_drop <= locked && !fibre_mode && !hold_reload
                      && hold == '0;
      end
   end

   // Descrambled or bypassed bit.
   // The keystream register holds the remote keystream itself, so a plain
   // XOR recovers the data; in fibre mode the bits pass untouched.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         desc_bit <= 1'b0;
         desc_v <= 1'b0;
      end else begin
         desc_v <= nrz_v && (fibre_mode || locked);
         desc_bit <= fibre_mode ? nrz : nrz ^ next_lfsr_bit;
      end
   end

   // Descrambled ones run for the hold timer.
   // It wraps after thirty, so a long idle gap reloads the timer often.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dones <= 6'h0;
      end else if (desc_v) begin
         if (!desc_bit || dones == IDLE_HOLD_BITS) dones <= 6'h0;
         else dones <= dones + 6'h1;
      end
   end

   // Alignment: shift in bits, fix the boundary on J/K.
   // The ten bits ahead of the delimiter are kept as well, so that a pair
   // that follows idle can be told from one that turns up mid-stream; the
   // alignment is released again after T/R or when a bad start is left.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         shreg <= '0;
         hist <= '0;
         ssd_idle <= 1'b0;
         aligned <= 1'b0;
         bitcnt <= 3'h0;
         sym_v <= 1'b0;
      end else begin
         sym_v <= 1'b0;
         if (!signal_ok || (!fibre_mode && !locked)) begin
            aligned <= 1'b0;
            bitcnt <= 3'h0;
         end else if (desc_v) begin
            shreg <= {shreg[8:0], desc_bit};
            hist <= {hist[8:0], shreg[9]};
            if (!aligned && {shreg[8:0], desc_bit} == CG_JK) begin
               aligned <= 1'b1;
               ssd_idle <= &{hist[8:0], shreg[9]};
               bitcnt <= 3'h0;
               sym_v <= 1'b1;
            end else if (aligned) begin
               if (bitcnt == 3'h4) begin
                  bitcnt <= 3'h0;
                  sym_v <= 1'b1;
               end else begin
                  bitcnt <= bitcnt + 3'h1;
               end
            end
         end
         if (state != FRX_DATA && sym_v && aligned && prev_sym == CG_T
             && shreg[4:0] == CG_R) aligned <= 1'b0;
         // Leaving a bad start must search for a fresh delimiter.
         if (ssd_exit) aligned <= 1'b0;
      end
   end

   assign sym = shreg[4:0];

   // Second idle in a row while reporting a bad start ends the error run.
   assign ssd_exit = sym_v && state == FRX_BADSSD && sym == CG_IDLE
                     && idle_cnt == 2'h1;

   // Table lookup on the aligned group; purely combinational.

   frx_dec5b u_dec (
      .code(sym),
      .nibble(dec_nib),
      .is_data(dec_ok)
   );

   // Idle tracking, previous symbol and stream state.
   // A J/K that was not preceded by idle, or any other non-idle group seen
   // with carrier up, is a bad start; it is reported as error nibbles until
   // two idle groups in a row bring the stream back to rest.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= FRX_IDLE;
         prev_sym <= CG_IDLE;
         idle_seen <= 1'b0;
         idle_cnt <= 2'h0;
         emit <= 1'b0;
         emit_word <= '0;
      end else begin
         emit <= 1'b0;
         if (!signal_ok) begin
            state <= FRX_IDLE;
         end else if (sym_v) begin
            prev_sym <= sym;
            unique case (state)
               FRX_IDLE: begin
                  if (shreg == CG_JK && (idle_seen || ssd_idle)) begin
                     state <= FRX_DATA;
                     emit <= 1'b1;
                     emit_word <= {1'b0, NIB_PRE};
                  end else if (carrier && sym != CG_IDLE) begin
                     state <= FRX_BADSSD;
                     idle_cnt <= 2'h0;
                  end
                  idle_seen <= (sym == CG_IDLE);
               end
               FRX_DATA: begin
                  if (sym == CG_T) begin
                     state <= FRX_IDLE;
                  end else begin
                     emit <= 1'b1;
                     emit_word <= {!dec_ok, dec_nib};
                  end
               end
               FRX_BADSSD: begin
                  emit <= 1'b1;
                  emit_word <= {1'b1, NIB_BADSSD};
                  if (sym == CG_IDLE) idle_cnt <= idle_cnt + 2'h1;
                  else idle_cnt <= 2'h0;
                  if (sym == CG_IDLE && idle_cnt == 2'h1) begin
                     state <= FRX_IDLE;
                     emit <= 1'b0;
                     idle_seen <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Second delimiter nibble follows the first; the K symbol itself.
   // It repeats the word still held in emit_word one cycle later.
   logic pre_second;
   always_ff @(posedge clk) begin
      if (!nrst) pre_second <= 1'b0;
      else pre_second <= emit && state == FRX_DATA && emit_word[3:0] == NIB_PRE
                         && prev_sym == CG_K && !dv_flag;
   end

   // Two-entry buffer: a stalled MAC costs no nibble while it has room.
   frx_buf2 u_buf (
      .clk(clk),
      .nrst(nrst),
      .in_valid(emit || pre_second),
      .in_data(emit_word),
      .in_ready(buf_ready),
      .out_valid(buf_valid),
      .out_data(buf_word),
      .out_ready(rx_ready || !rx_valid)
   );

   // Registered outputs toward the MAC.
   // Valid may only rise together with a nibble, so that the first word
   // seen with it is always the preamble; it falls once the stream has
   // ended and rx_ready is high, even when no nibble is being moved.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_data <= 4'h0;
         rx_er <= 1'b0;
         rx_dv <= 1'b0;
         rx_valid <= 1'b0;
         dv_flag <= 1'b0;
      end else begin
         if (state == FRX_DATA) dv_flag <= 1'b1;
         else dv_flag <= 1'b0;
         if (buf_valid && (rx_ready || !rx_valid)) begin
            rx_valid <= 1'b1;
            rx_data <= buf_word[3:0];
            rx_er <= buf_word[4];
            rx_dv <= (state == FRX_DATA) || dv_flag;
         end else if (rx_ready) begin
            rx_valid <= 1'b0;
            rx_er <= 1'b0;
            rx_dv <= rx_dv && (state == FRX_DATA);
         end
      end
   end

   // Lock indication.
   // Registered once more so that the status pin comes from a flip-flop.
   always_ff @(posedge clk) begin
      if (!nrst) scr_locked <= 1'b0;
      else scr_locked <= locked;
   end

endmodule : frx_rx_pcs

// *** verification/frx_mac_sink.sv ***
`timescale 1ns/1ps
module frx_mac_sink (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Handshake.
   input wire logic rx_valid,
   output logic rx_ready
);
   logic [1:0] low;

   // Random stalls, capped at three cycles so the line cannot overrun.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_ready <= 1'b0;
         low <= 2'h0;
      end else if (low == 2'h3 || $urandom_range(1, 0) == 1) begin
         rx_ready <= 1'b1;
         low <= 2'h0;
      end else begin
         rx_ready <= 1'b0;
         low <= low + 2'h1;
      end
   end
endmodule : frx_mac_sink

// *** verification/frx_rx_pcs_sva.sv ***
`timescale 1ns/1ps
module frx_rx_pcs_chk
   import frx_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Line side.
   input wire logic tp_bit_valid,
   input wire logic signal_ok,
   // Nibble stream.
   input wire logic [3:0] rx_data,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic scr_locked
);
   logic [5:0] seen;

   // Strobes seen since reset or unlock; lock needs a long run first.
   always_ff @(posedge clk) begin
      if (!nrst || scr_locked) seen <= 6'h00;
      else if (tp_bit_valid && seen != 6'h3F) seen <= seen + 6'h01;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   a_reset_quiet: assert property (disable iff (1'b0)
      !nrst |=> !rx_valid && !rx_dv && !rx_er && !scr_locked)
      else $error("outputs active after reset");
   a_reset_data: assert property (disable iff (1'b0)
      !nrst |=> rx_data == 4'h0) else $error("data not cleared by reset");
   a_bad_ssd: assert property (
      rx_valid && rx_er && !rx_dv |-> rx_data == NIB_BADSSD)
      else $error("bad start nibble wrong");
   a_out_stands: assert property (
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_er))
      else $error("stalled nibble changed");
   a_dv_stands: assert property (
      rx_valid && !rx_ready |=> $stable(rx_dv)) else $error("stalled dv moved");
   a_loss_drop: assert property (
      $fell(signal_ok) |-> ##[0:20] !rx_dv) else $error("dv kept on loss");
   a_pre_first: assert property (
      $rose(rx_dv) |-> rx_data == NIB_PRE) else $error("first nibble wrong");
   a_lock_bits: assert property (
      $rose(scr_locked) |-> seen >= 6'h28) else $error("lock too early");
   a_lock_hold: assert property (
      $rose(scr_locked) |=> scr_locked [*8]) else $error("lock lost early");

   c_lock: cover property ($rose(scr_locked));
   c_frame: cover property ($rose(rx_dv));
   c_stall: cover property (rx_valid && !rx_ready);
   c_err: cover property (rx_valid && rx_er && rx_dv);
   c_bad: cover property (rx_valid && rx_er && !rx_dv);
endmodule : frx_rx_pcs_chk

bind frx_rx_pcs frx_rx_pcs_chk u_chk (.clk(clk), .nrst(nrst),
   .tp_bit_valid(tp_bit_valid), .signal_ok(signal_ok), .rx_data(rx_data),
   .rx_dv(rx_dv), .rx_er(rx_er), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .scr_locked(scr_locked));

// *** verification/frx_rx_pcs_tb.sv ***
`timescale 1ns/1ps
module frx_rx_pcs_tb
   import frx_pkg::*;
;
   logic clk, nrst, fibre_mode, tp_bit, tp_bit_valid, fx_bit, fx_bit_valid;
   logic signal_ok, carrier, rx_dv, rx_er, rx_valid, rx_ready, scr_locked;
   logic line, ks;
   logic [3:0] rx_data;
   logic [10:0] lfsr;
   logic [6:0] e;
   logic [6:0] exp_q[$];
   logic [4:0] tbl[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
      5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   int fail_count, checked;

   frx_rx_pcs u_dut (.clk(clk), .nrst(nrst), .fibre_mode(fibre_mode),
      .tp_bit(tp_bit), .tp_bit_valid(tp_bit_valid), .fx_bit(fx_bit),
      .fx_bit_valid(fx_bit_valid), .signal_ok(signal_ok), .carrier(carrier),
      .rx_data(rx_data), .rx_dv(rx_dv), .rx_er(rx_er), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .scr_locked(scr_locked));
   frx_mac_sink u_mac (.clk(clk), .nrst(nrst), .rx_valid(rx_valid),
      .rx_ready(rx_ready));

   // Free-running receive clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic cmp(input string what, input logic [3:0] x, y);
      checked++;
      if (x !== y) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, x, y);
      end
   endtask : cmp

   // One line bit: scrambled on copper only, then NRZI, with random gaps.
   task automatic bit_out(input logic b);
      @(posedge clk);
      #1;
      tp_bit_valid = 1'b0;
      fx_bit_valid = 1'b0;
      if ($urandom_range(3, 0) == 0) begin
         @(posedge clk);
         #1;
      end
      ks = fibre_mode ? 1'b0 : lfsr[10] ^ lfsr[8];
      lfsr = {lfsr[9:0], lfsr[10] ^ lfsr[8]};
      line = line ^ b ^ ks;
      tp_bit = line;
      fx_bit = line;
      tp_bit_valid = !fibre_mode;
      fx_bit_valid = fibre_mode;
   endtask : bit_out

   // Lower the strobes so that no bit is taken again while the bench waits.
   task automatic quiet();
      @(posedge clk);
      #1;
      tp_bit_valid = 1'b0;
      fx_bit_valid = 1'b0;
   endtask : quiet

   task automatic cg(input logic [4:0] c);
      for (int i = 4; i >= 0; i--) bit_out(c[i]);
   endtask : cg

   // A frame: idle, J/K, nibbles, an optional bad group, then T/R.
   task automatic pkt(input int n, input logic [4:0] bad);
      logic [3:0] d;
      repeat (4) cg(CG_IDLE);
      carrier = 1'b1;
      exp_q.push_back({3'b110, NIB_PRE});
      exp_q.push_back({3'b110, NIB_PRE});
      cg(CG_J);
      cg(CG_K);
      for (int i = 0; i < n; i++) begin
         d = (n == 16) ? 4'(i) : 4'($urandom);
         exp_q.push_back({3'b110, d});
         cg(tbl[d]);
      end
      if (bad != CG_IDLE) begin
         exp_q.push_back(7'h50);
         cg(bad);
      end
      cg(CG_T);
      cg(CG_R);
      carrier = 1'b0;
      repeat (3) cg(CG_IDLE);
      cmp("rx_dv", 4'h0, {3'h0, rx_dv});
   endtask : pkt

   task automatic give_verdict();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // Delivered frame and error nibbles are matched against the oldest note.
   always @(posedge clk) begin
      if (nrst && rx_valid && rx_ready
          && (rx_dv === 1'b1 || rx_er === 1'b1)) begin
         if (exp_q.size() == 0) cmp("extra nibble", 4'h0, 4'hF);
         else begin
            e = exp_q.pop_front();
            cmp("rx_dv", {3'h0, e[6]}, {3'h0, rx_dv});
            cmp("rx_er", {3'h0, e[4]}, {3'h0, rx_er});
            if (e[5]) cmp("rx_data", e[3:0], rx_data);
         end
      end
   end

   // Watchdog against a hung run.
   initial begin
      #100000;
      fail_count++;
      give_verdict();
   end

   // Main sequence.
   initial begin
      void'($urandom(32'h26E35893));
      {nrst, tp_bit, tp_bit_valid, fx_bit, fx_bit_valid, carrier} = 6'h00;
      {fibre_mode, signal_ok, line} = 3'h2;
      lfsr = 11'h5A3;
      fail_count = 0;
      checked = 0;
      repeat (12) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (16) cg(CG_IDLE);
      cmp("scr_locked", 4'h1, {3'h0, scr_locked});
      pkt(6, CG_IDLE);
      quiet();
      fibre_mode = 1'b1;
      pkt(16, CG_IDLE);
      pkt(8, CG_H);
      pkt(4, 5'h00);
      // J/K after data groups is a bad start: two error nibbles follow.
      carrier = 1'b1;
      exp_q.push_back({3'b011, NIB_BADSSD});
      exp_q.push_back({3'b011, NIB_BADSSD});
      cg(tbl[6]);
      cg(tbl[6]);
      cg(CG_J);
      cg(CG_K);
      cg(tbl[3]);
      carrier = 1'b0;
      repeat (4) cg(CG_IDLE);
      quiet();
      repeat (40) @(posedge clk);
      cmp("notes left", 4'h0, 4'(exp_q.size()));
      // A frame cut by loss of signal: valid must drop without T/R.
      carrier = 1'b1;
      exp_q.push_back({3'b110, NIB_PRE});
      exp_q.push_back({3'b110, NIB_PRE});
      cg(CG_J);
      cg(CG_K);
      quiet();
      repeat (20) @(posedge clk);
      signal_ok = 1'b0;
      cg(tbl[3]);
      repeat (6) cg(CG_IDLE);
      cmp("rx_dv", 4'h0, {3'h0, rx_dv});
      cmp("notes left", 4'h0, 4'(exp_q.size()));
      give_verdict();
   end
endmodule : frx_rx_pcs_tb
